// ### include/drs_pkg.sv
// Shared constants and types of the dead-reckoning sensor front end
//
// Behaviour
// (RULE1) The block is the serial master: it drives clock, both selects and master-out, and samples master-in.
// (RULE2) The first select addresses only the converter that digitises the turn-rate sensor.
// (RULE3) The second select addresses only the temperature sensor on the shared bus.
// (RULE4) Out of reset and unless a divider is configured, the serial clock runs at 870 kHz; the code uses a half period of 11 cycles, about 909 kHz.
// (RULE5) A high level on the direction input means forward, a low level backward.
// (RULE6) The direction input has a pull-up, so an open input reads high and means forward.
// (RULE7) The meaning of the direction input is configurable, and without a direction signal it must be set to always forward.
// (RULE8) The direction setting affects only the dead-reckoning results, never the satellite-only ones.
// (RULE9) Speed pulses arrive between 1 Hz and 2 kHz, and no pulses at all means zero speed.
// (RULE10) The odometer's pulse rate is proportional to driven speed, so counting pulses gives speed and distance.
// (RULE11) The speed-pulse pin doubles as a general event input with a pull-up so an unused pin idles high.
// (RULE12) Selects are active low, never both asserted, and held for a whole transfer.
package drs_pkg;

  // ************************************************************
  // Clocking and serial timing
  // ************************************************************
  localparam int unsigned SYS_CLK_HZ      = 20_000_000;
  localparam int unsigned SCK_DEFAULT_KHZ = 870;
  localparam int unsigned SCK_DEFAULT_HZ  = SCK_DEFAULT_KHZ * 1000;
  localparam int unsigned SCK_DIV_W       = 8;
  // Half period rounded to the nearest whole cycle
  localparam logic [SCK_DIV_W-1:0] SCK_HALF_DEFAULT =
    SCK_DIV_W'((SYS_CLK_HZ + SCK_DEFAULT_HZ) / (2 * SCK_DEFAULT_HZ));
  localparam int unsigned FRAME_BITS = 16;
  localparam int unsigned BIT_CNT_W  = 5;
  localparam int unsigned DATA_W     = 16;

  // ************************************************************
  // Speed pulse timing
  // ************************************************************
  localparam int unsigned SPEED_MIN_HZ     = 1;
  localparam int unsigned SPEED_MAX_HZ     = 2000;
  localparam int unsigned ZERO_TIMEOUT_DEF = SYS_CLK_HZ / SPEED_MIN_HZ;
  localparam int unsigned MIN_INTERVAL_DEF = SYS_CLK_HZ / SPEED_MAX_HZ;
  localparam int unsigned TIMER_W          = 25;
  localparam int unsigned CNT_W            = 16;

  // ************************************************************
  // Pad control and modes
  // ************************************************************
  localparam logic PULLUP_ON = 1'b1;

  typedef enum logic [1:0] {
    DIR_FROM_PIN,
    DIR_FORCE_FWD,
    DIR_INVERTED
  } drs_dir_mode_e;

  typedef enum logic {
    TGT_RATE_ADC,
    TGT_TEMP
  } drs_target_e;

  typedef enum logic [1:0] {
    SPI_IDLE,
    SPI_LEAD,
    SPI_SHIFT,
    SPI_TRAIL
  } drs_spi_st_e;

endpackage

// ### rtl/drs_spi_master.sv
// Serial master engine with two exclusive selects
`timescale 1ns/100ps
module drs_spi_master (
  input  wire logic                           clk_sys_i,
  input  wire logic                           rst_n_i,
  input  wire logic                           start_i,
  input  wire drs_pkg::drs_target_e           target_i,
  input  wire logic [drs_pkg::DATA_W-1:0]     tx_data_i,
  input  wire logic [drs_pkg::SCK_DIV_W-1:0]  half_cfg_i,
  output logic                                busy_o,
  output logic                                done_o,
  output logic [drs_pkg::DATA_W-1:0]          rx_data_o,
  output logic                                spi_sck_o,
  output logic                                spi_mosi_o,
  input  wire logic                           spi_miso_i,
  output logic                                rate_adc_select_n_o,
  output logic                                temp_sensor_select_n_o
);
  import drs_pkg::*;

  drs_spi_st_e              state_r;
  logic [SCK_DIV_W-1:0]     div_r;
  logic [SCK_DIV_W-1:0]     half;
  logic                     tick;
  logic [BIT_CNT_W-1:0]     bit_r;
  logic [DATA_W-1:0]        tx_r;
  logic [DATA_W-1:0]        rx_r;
  logic                     miso_meta_r;
  logic                     miso_sync_r;

  // ************************************************************
  // Clock divider
  // ************************************************************
  assign half = (half_cfg_i == '0) ? SCK_HALF_DEFAULT : half_cfg_i; // RULE4
  assign tick = (div_r == '0);

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || state_r == SPI_IDLE) begin
      div_r <= half - 8'h01;
    end else if (tick) begin
      div_r <= half - 8'h01;
    end else begin
      div_r <= div_r - 8'h01;
    end
  end

  // ************************************************************
  // Master-in synchroniser
  // ************************************************************
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      miso_meta_r <= 1'b0;
      miso_sync_r <= 1'b0;
    end else begin
      miso_meta_r <= spi_miso_i;
      miso_sync_r <= miso_meta_r;
    end
  end

  // ************************************************************
  // Transfer sequence
  // ************************************************************
  // Sampling the synchronised line costs two cycles of the half period
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state_r                <= SPI_IDLE;
      spi_sck_o              <= 1'b0;
      spi_mosi_o             <= 1'b0;
      rate_adc_select_n_o    <= 1'b1;
      temp_sensor_select_n_o <= 1'b1;
      bit_r                  <= '0;
      tx_r                   <= '0;
      rx_r                   <= '0;
      rx_data_o              <= '0;
      done_o                 <= 1'b0;
    end else begin
      done_o <= 1'b0;
      unique case (state_r)
        SPI_IDLE: begin
          if (start_i) begin
            state_r                <= SPI_LEAD;
            rate_adc_select_n_o    <= (target_i != TGT_RATE_ADC); // RULE2
            temp_sensor_select_n_o <= (target_i != TGT_TEMP); // RULE3
            tx_r                   <= tx_data_i;
            spi_mosi_o             <= tx_data_i[DATA_W-1]; // RULE1
            bit_r                  <= '0;
          end
        end
        SPI_LEAD: begin
          if (tick) begin
            state_r   <= SPI_SHIFT;
            spi_sck_o <= 1'b1; // RULE1
            rx_r      <= {rx_r[DATA_W-2:0], miso_sync_r};
          end
        end
        SPI_SHIFT: begin
          if (tick) begin
            spi_sck_o <= ~spi_sck_o;
            if (spi_sck_o) begin
              tx_r       <= {tx_r[DATA_W-2:0], 1'b0};
              spi_mosi_o <= tx_r[DATA_W-2];
              bit_r      <= bit_r + 5'h01;
              if (bit_r == BIT_CNT_W'(FRAME_BITS - 1)) begin
                state_r <= SPI_TRAIL;
              end
            end else begin
              rx_r <= {rx_r[DATA_W-2:0], miso_sync_r}; // RULE1
            end
          end
        end
        SPI_TRAIL: begin
          if (tick) begin
            state_r                <= SPI_IDLE;
            rate_adc_select_n_o    <= 1'b1; // RULE12
            temp_sensor_select_n_o <= 1'b1; // RULE12
            rx_data_o              <= rx_r;
            done_o                 <= 1'b1;
          end
        end
      endcase
    end
  end

  assign busy_o = (state_r != SPI_IDLE);

endmodule // drs_spi_master

// ### rtl/drs_sensor_front.sv
// Dead-reckoning sensor front end: serial sensors, direction, speed pulses
`timescale 1ns/100ps
module drs_sensor_front #(
  parameter int unsigned ZERO_TIMEOUT_CYC = drs_pkg::ZERO_TIMEOUT_DEF,
  parameter int unsigned MIN_INTERVAL_CYC = drs_pkg::MIN_INTERVAL_DEF
) (
  input  wire logic                           clk_sys_i,
  input  wire logic                           rst_n_i,
  input  wire logic                           clk_link_i,
  // Serial sensor bus
  output logic                                spi_sck_o,
  output logic                                spi_mosi_o,
  input  wire logic                           spi_miso_i,
  output logic                                rate_adc_select_n_o,
  output logic                                temp_sensor_select_n_o,
  // Sensor read requests
  input  wire logic                           rate_req_i,
  input  wire logic                           temp_req_i,
  input  wire logic [drs_pkg::DATA_W-1:0]     rate_cmd_i,
  input  wire logic [drs_pkg::SCK_DIV_W-1:0]  sck_half_cfg_i,
  output logic                                spi_busy_o,
  output logic                                rate_valid_o,
  output logic [drs_pkg::DATA_W-1:0]          rate_data_o,
  output logic                                temp_valid_o,
  output logic [drs_pkg::DATA_W-1:0]          temp_data_o,
  // Direction
  input  wire logic                           direction_in_i,
  input  wire drs_pkg::drs_dir_mode_e         dir_mode_i,
  output logic                                direction_pullup_en_o,
  output logic                                dead_reckoning_fwd_o,
  // Speed pulses and general event
  input  wire logic                           external_event_in_i,
  output logic                                external_event_pullup_en_o,
  output logic                                external_event_o,
  output logic                                speed_pulse_o,
  output logic [drs_pkg::CNT_W-1:0]           speed_pulse_total_o,
  output logic [drs_pkg::CNT_W-1:0]           dead_reckoning_dist_o,
  output logic [drs_pkg::TIMER_W-1:0]         speed_period_o,
  output logic                                vehicle_stopped_o,
  output logic                                speed_over_rate_o
);
  import drs_pkg::*;

  function automatic logic [CNT_W-1:0] gray2bin(input logic [CNT_W-1:0] g);
    logic [CNT_W-1:0] b;
    b[CNT_W-1] = g[CNT_W-1];
    for (int i = CNT_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  localparam logic [TIMER_W-1:0] ZERO_TO = TIMER_W'(ZERO_TIMEOUT_CYC);
  localparam logic [TIMER_W-1:0] MIN_IV  = TIMER_W'(MIN_INTERVAL_CYC);

  // ************************************************************
  // Request arbitration
  // ************************************************************
  logic        rate_pend_r;
  logic        temp_pend_r;
  logic        start;
  drs_target_e target;
  drs_target_e cur_tgt_r;
  logic        spi_done;
  logic [DATA_W-1:0] spi_rx;
  logic        spi_busy;

  // One engine serves both parts, so only one select can ever be low
  assign start  = !spi_busy && (rate_pend_r || temp_pend_r); // RULE12
  assign target = rate_pend_r ? TGT_RATE_ADC : TGT_TEMP;
  assign spi_busy_o = spi_busy;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rate_pend_r <= 1'b0;
      temp_pend_r <= 1'b0;
    end else begin
      // A new request in the cycle of the launch is kept pending
      if (rate_req_i) begin
        rate_pend_r <= 1'b1;
      end else if (start && target == TGT_RATE_ADC) begin
        rate_pend_r <= 1'b0;
      end
      if (temp_req_i) begin
        temp_pend_r <= 1'b1;
      end else if (start && target == TGT_TEMP) begin
        temp_pend_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      cur_tgt_r <= TGT_RATE_ADC;
    end else if (start) begin
      cur_tgt_r <= target;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rate_valid_o <= 1'b0;
      temp_valid_o <= 1'b0;
      rate_data_o  <= '0;
      temp_data_o  <= '0;
    end else begin
      rate_valid_o <= spi_done && cur_tgt_r == TGT_RATE_ADC; // RULE2
      temp_valid_o <= spi_done && cur_tgt_r == TGT_TEMP; // RULE3
      if (spi_done && cur_tgt_r == TGT_RATE_ADC) begin
        rate_data_o <= spi_rx;
      end
      if (spi_done && cur_tgt_r == TGT_TEMP) begin
        temp_data_o <= spi_rx;
      end
    end
  end

  drs_spi_master u_spi (
    .clk_sys_i              (clk_sys_i),
    .rst_n_i                (rst_n_i),
    .start_i                (start),
    .target_i               (target),
    .tx_data_i              ((target == TGT_RATE_ADC) ? rate_cmd_i : '0),
    .half_cfg_i             (sck_half_cfg_i),
    .busy_o                 (spi_busy),
    .done_o                 (spi_done),
    .rx_data_o              (spi_rx),
    .spi_sck_o              (spi_sck_o),
    .spi_mosi_o             (spi_mosi_o),
    .spi_miso_i             (spi_miso_i),
    .rate_adc_select_n_o    (rate_adc_select_n_o),
    .temp_sensor_select_n_o (temp_sensor_select_n_o)
  );

  // ************************************************************
  // Direction
  // ************************************************************
  logic dir_meta_r;
  logic dir_sync_r;
  logic fwd_nxt;

  // Pad pull-ups make open inputs read high
  assign direction_pullup_en_o      = PULLUP_ON; // RULE6
  assign external_event_pullup_en_o = PULLUP_ON; // RULE11

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      dir_meta_r <= 1'b1;
      dir_sync_r <= 1'b1;
    end else begin
      dir_meta_r <= direction_in_i;
      dir_sync_r <= dir_meta_r;
    end
  end

  always_comb begin
    unique case (dir_mode_i)
      DIR_FROM_PIN:  fwd_nxt = dir_sync_r; // RULE5
      DIR_FORCE_FWD: fwd_nxt = 1'b1; // RULE7
      DIR_INVERTED:  fwd_nxt = ~dir_sync_r; // RULE7
      default:       fwd_nxt = dir_sync_r;
    endcase
  end

  // Only the dead-reckoning outputs see the direction
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      dead_reckoning_fwd_o <= 1'b1;
    end else begin
      dead_reckoning_fwd_o <= fwd_nxt; // RULE8
    end
  end

  // ************************************************************
  // Link-side pulse counter
  // ************************************************************
  logic             lrst_meta_r;
  logic             lrst_n_r;
  logic             spd_meta_r;
  logic             spd_sync_r;
  logic             spd_prev_r;
  logic [CNT_W-1:0] lbin_r;
  logic [CNT_W-1:0] lgray_r;

  always_ff @(posedge clk_link_i) begin
    lrst_meta_r <= rst_n_i;
    lrst_n_r    <= lrst_meta_r;
  end

  always_ff @(posedge clk_link_i) begin
    if (!lrst_n_r) begin
      spd_meta_r <= 1'b1;
      spd_sync_r <= 1'b1;
      spd_prev_r <= 1'b1;
    end else begin
      spd_meta_r <= external_event_in_i;
      spd_sync_r <= spd_meta_r;
      spd_prev_r <= spd_sync_r;
    end
  end

  // Gray code lets the whole count cross with one bit moving at a time
  always_ff @(posedge clk_link_i) begin
    if (!lrst_n_r) begin
      lbin_r  <= '0;
      lgray_r <= '0;
    end else if (spd_sync_r && !spd_prev_r) begin
      lbin_r  <= lbin_r + 16'h0001; // RULE10
      lgray_r <= (lbin_r + 16'h0001) ^ ((lbin_r + 16'h0001) >> 1);
    end
  end

  // ************************************************************
  // System-side pulse evaluation
  // ************************************************************
  logic [CNT_W-1:0]   gmeta_r;
  logic [CNT_W-1:0]   gsync_r;
  logic [CNT_W-1:0]   count_nxt;
  logic               ext_meta_r;
  logic               ext_sync_r;
  logic               pulse;
  logic [TIMER_W-1:0] since_r;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      gmeta_r <= '0;
      gsync_r <= '0;
    end else begin
      gmeta_r <= lgray_r;
      gsync_r <= gmeta_r;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ext_meta_r       <= 1'b1;
      ext_sync_r       <= 1'b1;
      external_event_o <= 1'b1;
    end else begin
      ext_meta_r       <= external_event_in_i;
      ext_sync_r       <= ext_meta_r;
      external_event_o <= ext_sync_r; // RULE11
    end
  end

  assign count_nxt = gray2bin(gsync_r);
  assign pulse     = (count_nxt != speed_pulse_total_o);

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      speed_pulse_total_o <= '0;
      speed_pulse_o       <= 1'b0;
    end else begin
      speed_pulse_total_o <= count_nxt; // RULE10
      speed_pulse_o       <= pulse;
    end
  end

  // Signed distance in pulses, counted down while backing up
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      dead_reckoning_dist_o <= '0;
    end else if (pulse) begin
      if (dead_reckoning_fwd_o) begin
        dead_reckoning_dist_o <= dead_reckoning_dist_o + 16'h0001; // RULE8
      end else begin
        dead_reckoning_dist_o <= dead_reckoning_dist_o - 16'h0001; // RULE8
      end
    end
  end

  // Saturating time since the last pulse
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      since_r <= '0;
    end else if (pulse) begin
      since_r <= '0;
    end else if (since_r != ZERO_TO) begin
      since_r <= since_r + 25'h0000001;
    end
  end

  // Below the lowest rate the vehicle is taken as standing still
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      vehicle_stopped_o <= 1'b1;
      speed_period_o    <= '0;
    end else if (pulse) begin
      vehicle_stopped_o <= 1'b0;
      speed_period_o    <= vehicle_stopped_o ? '0 : since_r + 25'h0000001;
    end else if (since_r == ZERO_TO) begin
      vehicle_stopped_o <= 1'b1; // RULE9
      speed_period_o    <= '0; // RULE9
    end
  end

  // Pulses closer than the highest rate allows are flagged
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      speed_over_rate_o <= 1'b0;
    end else if (pulse) begin
      speed_over_rate_o <= !vehicle_stopped_o &&
                           (since_r + 25'h0000001 < MIN_IV); // RULE9
    end else if (since_r == ZERO_TO) begin
      speed_over_rate_o <= 1'b0;
    end
  end

endmodule // drs_sensor_front

// ### bench/drs_front_chk.sv
// Port checker of the dead-reckoning sensor front end
`timescale 1ns/100ps
module drs_front_chk
  import drs_pkg::*;
(
  input wire logic                 clk_sys_i,
  input wire logic                 rst_n_i,
  input wire logic                 spi_sck_o,
  input wire logic                 rate_adc_select_n_o,
  input wire logic                 temp_sensor_select_n_o,
  input wire logic                 spi_busy_o,
  input wire logic                 rate_valid_o,
  input wire logic                 temp_valid_o,
  input wire logic [SCK_DIV_W-1:0] sck_half_cfg_i,
  input wire drs_dir_mode_e        dir_mode_i,
  input wire logic                 direction_pullup_en_o,
  input wire logic                 external_event_pullup_en_o,
  input wire logic                 dead_reckoning_fwd_o,
  input wire logic                 speed_pulse_o,
  input wire logic [CNT_W-1:0]     speed_pulse_total_o,
  input wire logic [CNT_W-1:0]     dead_reckoning_dist_o,
  input wire logic                 vehicle_stopped_o
);
  // ****************************************
  // Helper: cycles since sck last changed
  // ****************************************
  logic       sck_d_r;
  logic [7:0] hcnt_r;
  always_ff @(posedge clk_sys_i) begin
    sck_d_r <= rst_n_i ? spi_sck_o : 1'b0;
    if (!rst_n_i || spi_sck_o != sck_d_r) begin
      hcnt_r <= 8'h00;
    end else if (hcnt_r != 8'hFF) begin
      hcnt_r <= hcnt_r + 8'h01;
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  sel_excl_a: assert property (
    rate_adc_select_n_o || temp_sensor_select_n_o)
    else $error("both selects low");
  sck_idle_a: assert property (
    rate_adc_select_n_o && temp_sensor_select_n_o |-> !spi_sck_o)
    else $error("sck active outside frame");
  busy_sel_a: assert property (
    spi_busy_o == !(rate_adc_select_n_o && temp_sensor_select_n_o))
    else $error("busy differs from select");
  rate_done_a: assert property (
    $rose(rate_adc_select_n_o) |=> rate_valid_o && !temp_valid_o)
    else $error("rate frame without rate result");
  temp_done_a: assert property (
    $rose(temp_sensor_select_n_o) |=> temp_valid_o && !rate_valid_o)
    else $error("temp frame without temp result");
  sck_half_a: assert property (
    $fell(spi_sck_o) && sck_half_cfg_i == 8'h00 |->
      hcnt_r == SCK_HALF_DEFAULT - 8'h01)
    else $error("default sck half period wrong");
  pulse_count_a: assert property (
    speed_pulse_o |-> speed_pulse_total_o == $past(speed_pulse_total_o) + 16'h0001)
    else $error("pulse total not stepped");
  dist_dir_a: assert property (
    speed_pulse_o |-> dead_reckoning_dist_o == ($past(dead_reckoning_fwd_o) ?
      $past(dead_reckoning_dist_o) + 16'h0001 :
      $past(dead_reckoning_dist_o) - 16'h0001))
    else $error("distance step wrong");
  pulse_move_a: assert property (
    speed_pulse_o |=> !vehicle_stopped_o)
    else $error("stopped after pulse");
  force_fwd_a: assert property (
    dir_mode_i == DIR_FORCE_FWD && $past(dir_mode_i) == DIR_FORCE_FWD
      |-> dead_reckoning_fwd_o)
    else $error("forced forward not kept");
  pull_up_a: assert property (
    direction_pullup_en_o && external_event_pullup_en_o)
    else $error("pad pull-up off");
  cover property (rate_valid_o);
  cover property (temp_valid_o);
  cover property ($rose(vehicle_stopped_o));
endmodule // drs_front_chk

bind drs_sensor_front drs_front_chk u_chk (
  .clk_sys_i, .rst_n_i, .spi_sck_o, .rate_adc_select_n_o,
  .temp_sensor_select_n_o, .spi_busy_o, .rate_valid_o, .temp_valid_o,
  .sck_half_cfg_i, .dir_mode_i, .direction_pullup_en_o,
  .external_event_pullup_en_o, .dead_reckoning_fwd_o, .speed_pulse_o,
  .speed_pulse_total_o, .dead_reckoning_dist_o, .vehicle_stopped_o
);

// ### bench/drs_sensor_model.sv
// Behavioural model of the rate converter and temperature sensor
`timescale 1ns/100ps
module drs_sensor_model #(
  parameter logic [15:0] RATE_WORD = 16'hA5C3,
  parameter logic [15:0] TEMP_WORD = 16'h0C80
) (
  input  wire logic        spi_sck_i,
  input  wire logic        spi_mosi_i,
  input  wire logic        rate_sel_n_i,
  input  wire logic        temp_sel_n_i,
  output logic             spi_miso_o,
  output logic [15:0]      rx_word_o
);
  logic [15:0] shift_r = 16'h0000;
  wire         idle    = rate_sel_n_i && temp_sel_n_i;
  initial spi_miso_o = 1'b0;
  initial rx_word_o = 16'h0000;
  // Released line toggles so a stale bit never passes for data
  always #17 if (idle) spi_miso_o = ~spi_miso_o;
  always @(negedge rate_sel_n_i) begin
    shift_r = RATE_WORD;
    spi_miso_o = RATE_WORD[15];
  end
  always @(negedge temp_sel_n_i) begin
    shift_r = TEMP_WORD;
    spi_miso_o = TEMP_WORD[15];
  end
  always @(posedge spi_sck_i) if (!idle) rx_word_o = {rx_word_o[14:0], spi_mosi_i};
  always @(negedge spi_sck_i) if (!idle) begin
    shift_r = shift_r << 1;
    spi_miso_o = shift_r[15];
  end
endmodule // drs_sensor_model

// ### bench/drs_sensor_front_tb.sv
// Self-checking bench of the dead-reckoning sensor front end
`timescale 1ns/100ps
module drs_sensor_front_tb;
  import drs_pkg::*;
  localparam int unsigned ZT = 2000;
  logic clk_sys_i = 1'b0, clk_link_i = 1'b0, rst_n_i = 1'b0;
  logic rate_req_i = 1'b0, temp_req_i = 1'b0, direction_in_i = 1'b1;
  logic external_event_in_i = 1'b1;
  logic [DATA_W-1:0] rate_cmd_i = 16'h6E19;
  logic [SCK_DIV_W-1:0] sck_half_cfg_i = 8'h00;
  drs_dir_mode_e dir_mode_i = DIR_FROM_PIN;
  logic spi_sck_o, spi_mosi_o, spi_miso_i, rate_adc_select_n_o, spi_busy_o;
  logic temp_sensor_select_n_o, rate_valid_o, temp_valid_o, speed_pulse_o;
  logic direction_pullup_en_o, dead_reckoning_fwd_o, external_event_o;
  logic external_event_pullup_en_o, vehicle_stopped_o, speed_over_rate_o;
  logic [DATA_W-1:0] rate_data_o, temp_data_o;
  logic [CNT_W-1:0] speed_pulse_total_o, dead_reckoning_dist_o, e_tot, e_dst;
  logic [TIMER_W-1:0] speed_period_o;
  logic [15:0] rx_word;
  int n_fail = 0;
  int comparisons = 0;
  int n;
  always #25 clk_sys_i = ~clk_sys_i;
  initial begin
    #1.3;
    forever #3 clk_link_i = ~clk_link_i;
  end
  drs_sensor_front #(.ZERO_TIMEOUT_CYC(ZT), .MIN_INTERVAL_CYC(100)) uut (
    .clk_sys_i, .rst_n_i, .clk_link_i, .spi_sck_o, .spi_mosi_o, .spi_miso_i,
    .rate_adc_select_n_o, .temp_sensor_select_n_o, .rate_req_i, .temp_req_i,
    .rate_cmd_i, .sck_half_cfg_i, .spi_busy_o, .rate_valid_o, .rate_data_o,
    .temp_valid_o, .temp_data_o, .direction_in_i, .dir_mode_i,
    .direction_pullup_en_o, .dead_reckoning_fwd_o, .external_event_in_i,
    .external_event_pullup_en_o, .external_event_o, .speed_pulse_o,
    .speed_pulse_total_o, .dead_reckoning_dist_o, .speed_period_o,
    .vehicle_stopped_o, .speed_over_rate_o);
  drs_sensor_model u_model (.spi_sck_i(spi_sck_o), .spi_mosi_i(spi_mosi_o),
    .rate_sel_n_i(rate_adc_select_n_o), .temp_sel_n_i(temp_sensor_select_n_o),
    .spi_miso_o(spi_miso_i), .rx_word_o(rx_word));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic complete_run;
    $display("fails %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clk_sys_i);
  endtask
  // Bounded wait; cycles from the taking edge to the result
  task automatic wait_valid(input bit tmp, output int c);
    c = 0;
    do begin
      @(posedge clk_sys_i);
      #1;
      c++;
    end while ((tmp ? temp_valid_o : rate_valid_o) !== 1'b1 && c < 3000);
    if (c >= 3000) begin
      chk("valid", 1, 0);
      complete_run();
    end
  endtask
  task automatic request(input bit r, t);
    @(posedge clk_sys_i);
    rate_req_i <= r;
    temp_req_i <= t;
    @(posedge clk_sys_i);
    rate_req_i <= 1'b0;
    temp_req_i <= 1'b0;
  endtask
  // Pin idles high; a pulse is a low phase then a rising edge
  task automatic pulse(input int lo, hi, input bit fw);
    @(posedge clk_sys_i);
    external_event_in_i <= 1'b0;
    tick(lo);
    chk("event copy", 0, external_event_o);
    external_event_in_i <= 1'b1;
    tick(hi);
    e_tot = e_tot + 16'h0001;
    e_dst = fw ? e_dst + 16'h0001 : e_dst - 16'h0001;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    tick(2);
    #1;
    chk("selects", 3, {rate_adc_select_n_o, temp_sensor_select_n_o});
    chk("sck", 0, spi_sck_o);
    chk("pull-ups", 3, {direction_pullup_en_o, external_event_pullup_en_o});
    chk("reset state", 7, {vehicle_stopped_o, dead_reckoning_fwd_o, external_event_o});
    chk("total", 0, speed_pulse_total_o);
    @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
  endtask
  task automatic t_rate;
    request(1, 0);
    wait_valid(0, n);
    chk("rate time", 2 + 33 * SCK_HALF_DEFAULT, n);
    chk("rate data", 16'hA5C3, rate_data_o);
    chk("command", 16'h6E19, rx_word);
    chk("temp data", 0, temp_data_o);
  endtask
  task automatic t_temp;
    request(0, 1);
    wait_valid(1, n);
    chk("temp data", 16'h0C80, temp_data_o);
    chk("temp mosi", 0, rx_word);
  endtask
  task automatic t_both;
    @(posedge clk_sys_i);
    sck_half_cfg_i <= 8'h04;
    rate_cmd_i <= 16'h93E6;
    request(1, 1);
    wait_valid(0, n);
    chk("rate first", 2 + 33 * 4, n);
    chk("command", 16'h93E6, rx_word);
    wait_valid(1, n);
    chk("temp next", 16'h0C80, temp_data_o);
  endtask
  task automatic t_dir;
    for (int m = 0; m < 4; m++) begin
      for (int p = 0; p < 2; p++) begin
        @(posedge clk_sys_i);
        dir_mode_i <= drs_dir_mode_e'(m[1:0]);
        direction_in_i <= p[0];
        tick(6);
        chk("forward", m == 1 ? 1 : m == 2 ? !p : p, dead_reckoning_fwd_o);
      end
    end
    @(posedge clk_sys_i);
    dir_mode_i <= DIR_FROM_PIN;
  endtask
  task automatic t_speed;
    e_tot = 16'h0000;
    e_dst = 16'h0000;
    repeat (3) pulse(150, 20, 1);
    chk("total", e_tot, speed_pulse_total_o);
    chk("distance", e_dst, dead_reckoning_dist_o);
    chk("moving", 0, {vehicle_stopped_o, speed_over_rate_o});
    chk("period", 1, speed_period_o >= 169 && speed_period_o <= 171);
    @(posedge clk_sys_i);
    direction_in_i <= 1'b0;
    tick(6);
    repeat (2) pulse(150, 20, 0);
    chk("backward", e_dst, dead_reckoning_dist_o);
    repeat (2) pulse(40, 20, 0);
    chk("over rate", 1, speed_over_rate_o);
    chk("total", e_tot, speed_pulse_total_o);
    tick(ZT + 100);
    chk("stopped", 1, vehicle_stopped_o);
    chk("stop period", 0, speed_period_o);
  endtask
  initial begin
    t_reset();
    t_rate();
    t_temp();
    t_both();
    t_dir();
    t_speed();
    complete_run();
  end
endmodule // drs_sensor_front_tb
